// *** verilog/dual_gpio_port_mux.sv ***
// How it works
// - G selector per pin: 00 input, 01 output
// - G code 10 feeds interrupt line n+8
// - G code 11 selects timer, UART1, SPI, LCD
// - Data read: pad level inputs, written bit outputs
// - Pull-up bit 0 enables, 1 disables
// - H selector per pin: 00 input, 01 output
// - H code 10 selects clocks and UART pins
// - H code 11: UART1 handshake on pins 7/6
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module dual_gpio_port_mux (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// AXI4-Lite write
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [gpio_mux_pkg::BUS_W-1:0] s_axi_wdata,
	input wire logic [gpio_mux_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [gpio_mux_pkg::BUS_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port G pads
	input wire logic [gpio_mux_pkg::G_PINS-1:0] gPadIn,
	output logic [gpio_mux_pkg::G_PINS-1:0] gPadOut,
	output logic [gpio_mux_pkg::G_PINS-1:0] gPadOe,
	output logic [gpio_mux_pkg::G_PINS-1:0] gPullupEn,
	// Port H pads
	input wire logic [gpio_mux_pkg::H_PINS-1:0] hPadIn,
	output logic [gpio_mux_pkg::H_PINS-1:0] hPadOut,
	output logic [gpio_mux_pkg::H_PINS-1:0] hPadOe,
	output logic [gpio_mux_pkg::H_PINS-1:0] hPullupEn,
	// Port G peripheral lines
	output logic [gpio_mux_pkg::EXTERNAL_INTERRUPT_LINE_TOP:gpio_mux_pkg::EXTERNAL_INTERRUPT_LINE_BASE] externalInterruptLine,
	output logic timerClockInOne,
	output logic uart1ClearToSendN,
	input wire logic uart1RequestToSendN,
	input wire gpio_mux_pkg::spi_pins_t spi1DriveOut,
	input wire gpio_mux_pkg::spi_pins_t spi1DriveOe,
	output gpio_mux_pkg::spi_pins_t spi1PadIn,
	input wire logic serialPeriph0SelectNOut,
	input wire logic serialPeriph0SelectNOe,
	output logic serialPeriph0SelectNIn,
	input wire logic displayPowerDown,
	// Port H peripheral lines
	input wire logic clockOutputOne,
	input wire logic clockOutputZero,
	output logic uartExternalClock,
	input wire logic [2:0] uartTxd,
	output logic [2:0] uartRxd,
	input wire logic uart0RequestToSendN,
	output logic uart0ClearToSendN
);
	import gpio_mux_pkg::*;
	// ==========================================
	// State
	logic [G_CFG_W-1:0] gCfg_q, gCfg_d;
	logic [G_PINS-1:0] gDat_q, gDat_d, gUp_q, gUp_d;
	logic [H_CFG_W-1:0] hCfg_q, hCfg_d;
	logic [H_PINS-1:0] hDat_q, hDat_d, hUp_q, hUp_d;
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [31:0] awAddr_q, awAddr_d;
	logic [BUS_W-1:0] wData_q, wData_d;
	logic [STRB_W-1:0] wStrb_q, wStrb_d;
	logic awReady_q, awReady_d, wReady_q, wReady_d, arReady_q, arReady_d;
	logic bValid_q, bValid_d, rValid_q, rValid_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic [BUS_W-1:0] rData_q, rData_d;
	logic wrHit, awFire, wFire, arFire;
	logic [G_PINS-1:0] gLive, gAltAOut, gAltAOe, gAltBOut, gAltBOe;
	logic [H_PINS-1:0] hLive, hAltAOut, hAltAOe, hAltBOut, hAltBOe;
	logic [G_PINS-1:0][SEL_W-1:0] gSel;
	logic [H_PINS-1:0][SEL_W-1:0] hSel;
	logic [EXTERNAL_INTERRUPT_LINE_TOP:EXTERNAL_INTERRUPT_LINE_BASE] external_interrupt_line_d;
	logic timerClk_d, uart1Cts_d, spi0Sel_d, uart_external_clock_d, uart0Cts_d;
	spi_pins_t spi1In_d;
	logic [2:0] uartRxd_d;
	function automatic logic [BUS_W-1:0] mergeBytes(input logic [BUS_W-1:0] old,
		input logic [BUS_W-1:0] nw, input logic [STRB_W-1:0] strb);
		logic [BUS_W-1:0] res;
		res = old;
		for (int b = 0; b < STRB_W; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction
	// ==========================================
	// Per-pin cells, port G
	for (genvar i = 0; i < G_PINS; i++) begin : g_pin
		assign gSel[i] = gCfg_q[SEL_W*i +: SEL_W];
		// Alternate pins read the pad; the value carries no promise
		assign gLive[i] = (gSel[i] == SEL_OUTPUT) ? gDat_q[i] : gPadIn[i];
		assign external_interrupt_line_d[EXTERNAL_INTERRUPT_LINE_BASE+i] = (gSel[i] == SEL_ALT_A) & gPadIn[i];
		gpio_pin_cell u_cell (
			.core_clk(core_clk),
			.nrst(nrst),
			.sel(pin_sel_t'(gSel[i])),
			.dataBit(gDat_q[i]),
			.pullupDisable(gUp_q[i]),
			.altAOut(gAltAOut[i]),
			.altAOe(gAltAOe[i]),
			.altBOut(gAltBOut[i]),
			.altBOe(gAltBOe[i]),
			.padOut(gPadOut[i]),
			.padOe(gPadOe[i]),
			.pullupEn(gPullupEn[i])
		);
	end

	// ==========================================
	// Per-pin cells, port H
	for (genvar i = 0; i < H_PINS; i++) begin : h_pin
		assign hSel[i] = hCfg_q[SEL_W*i +: SEL_W];
		assign hLive[i] = (hSel[i] == SEL_OUTPUT) ? hDat_q[i] : hPadIn[i];
		gpio_pin_cell u_cell (
			.core_clk(core_clk),
			.nrst(nrst),
			.sel(pin_sel_t'(hSel[i])),
			.dataBit(hDat_q[i]),
			.pullupDisable(hUp_q[i]),
			.altAOut(hAltAOut[i]),
			.altAOe(hAltAOe[i]),
			.altBOut(hAltBOut[i]),
			.altBOe(hAltBOe[i]),
			.padOut(hPadOut[i]),
			.padOe(hPadOe[i]),
			.pullupEn(hPullupEn[i])
		);
	end

	// ==========================================
	// Alternate function routing
	always_comb begin
		// Interrupt lines are inputs, so code 10 on G never drives
		gAltAOut = '0;
		gAltAOe = '0;
		gAltBOut = '0;
		gAltBOe = '0;
		gAltBOut[PG_UART1_RTS] = uart1RequestToSendN;
		gAltBOe[PG_UART1_RTS] = 1'h1;
		gAltBOut[PG_SPI1_CLK] = spi1DriveOut.clock;
		gAltBOe[PG_SPI1_CLK] = spi1DriveOe.clock;
		gAltBOut[PG_SPI1_MOSI] = spi1DriveOut.masterOut;
		gAltBOe[PG_SPI1_MOSI] = spi1DriveOe.masterOut;
		gAltBOut[PG_SPI1_MISO] = spi1DriveOut.masterIn;
		gAltBOe[PG_SPI1_MISO] = spi1DriveOe.masterIn;
		gAltBOut[PG_LCD_PD] = displayPowerDown;
		gAltBOe[PG_LCD_PD] = 1'h1;
		gAltBOut[PG_SPI1_SEL] = spi1DriveOut.selectN;
		gAltBOe[PG_SPI1_SEL] = spi1DriveOe.selectN;
		gAltBOut[PG_SPI0_SEL] = serialPeriph0SelectNOut;
		gAltBOe[PG_SPI0_SEL] = serialPeriph0SelectNOe;
		hAltAOut = '0;
		hAltAOe = '0;
		hAltBOut = '0;
		hAltBOe = '0;
		hAltAOut[PH_CLOCK_OUTPUT_ONE] = clockOutputOne;
		hAltAOe[PH_CLOCK_OUTPUT_ONE] = 1'h1;
		hAltAOut[PH_CLOCK_OUTPUT_ZERO] = clockOutputZero;
		hAltAOe[PH_CLOCK_OUTPUT_ZERO] = 1'h1;
		hAltAOut[PH_TXD2] = uartTxd[2];
		hAltAOe[PH_TXD2] = 1'h1;
		hAltAOut[PH_TXD1] = uartTxd[1];
		hAltAOe[PH_TXD1] = 1'h1;
		hAltAOut[PH_TXD0] = uartTxd[0];
		hAltAOe[PH_TXD0] = 1'h1;
		hAltAOut[PH_UART0_RTS] = uart0RequestToSendN;
		hAltAOe[PH_UART0_RTS] = 1'h1;
		hAltBOut[PH_TXD2] = uart1RequestToSendN;
		hAltBOe[PH_TXD2] = 1'h1;
	end

	// ==========================================
	// Peripheral inputs; unselected lines rest idle
	always_comb begin
		timerClk_d = (gSel[PG_TIMER_CLK] == SEL_ALT_B) & gPadIn[PG_TIMER_CLK];
		// Either pin may carry the handshake; both selected gives a wired AND
		uart1Cts_d = ((gSel[PG_UART1_CTS] != SEL_ALT_B) | gPadIn[PG_UART1_CTS])
			& ((hSel[PH_RXD2] != SEL_ALT_B) | hPadIn[PH_RXD2]);
		spi1In_d.clock = (gSel[PG_SPI1_CLK] == SEL_ALT_B) & gPadIn[PG_SPI1_CLK];
		spi1In_d.masterOut = (gSel[PG_SPI1_MOSI] == SEL_ALT_B) & gPadIn[PG_SPI1_MOSI];
		spi1In_d.masterIn = (gSel[PG_SPI1_MISO] == SEL_ALT_B) & gPadIn[PG_SPI1_MISO];
		spi1In_d.selectN = (gSel[PG_SPI1_SEL] != SEL_ALT_B) | gPadIn[PG_SPI1_SEL];
		spi0Sel_d = (gSel[PG_SPI0_SEL] != SEL_ALT_B) | gPadIn[PG_SPI0_SEL];
		uart_external_clock_d = (hSel[PH_UART_CLK] == SEL_ALT_A) & hPadIn[PH_UART_CLK];
		uartRxd_d[2] = (hSel[PH_RXD2] != SEL_ALT_A) | hPadIn[PH_RXD2];
		uartRxd_d[1] = (hSel[PH_RXD1] != SEL_ALT_A) | hPadIn[PH_RXD1];
		uartRxd_d[0] = (hSel[PH_RXD0] != SEL_ALT_A) | hPadIn[PH_RXD0];
		uart0Cts_d = (hSel[PH_UART0_CTS] != SEL_ALT_A) | hPadIn[PH_UART0_CTS];
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			{externalInterruptLine, timerClockInOne, uartExternalClock} <= '0;
			{uart1ClearToSendN, serialPeriph0SelectNIn, uartRxd, uart0ClearToSendN} <= '1;
			spi1PadIn <= '{clock: 1'h0, masterOut: 1'h0, masterIn: 1'h0, selectN: 1'h1};
		end else begin
			{externalInterruptLine, timerClockInOne, uartExternalClock} <= {external_interrupt_line_d, timerClk_d, uart_external_clock_d};
			{uart1ClearToSendN, serialPeriph0SelectNIn, uart0ClearToSendN} <= {uart1Cts_d, spi0Sel_d, uart0Cts_d};
			{spi1PadIn, uartRxd} <= {spi1In_d, uartRxd_d};
		end
	end

	// ==========================================
	// Register bus
	always_comb begin
		{gCfg_d, gDat_d, gUp_d, hCfg_d, hDat_d, hUp_d} = {gCfg_q, gDat_q, gUp_q, hCfg_q, hDat_q, hUp_q};
		{awHeld_d, awAddr_d, wHeld_d, wData_d, wStrb_d} = {awHeld_q, awAddr_q, wHeld_q, wData_q, wStrb_q};
		{bValid_d, bResp_d, rValid_d, rResp_d, rData_d} = {bValid_q, bResp_q, rValid_q, rResp_q, rData_q};
		wrHit = 1'h1;
		awFire = s_axi_awvalid & awReady_q;
		wFire = s_axi_wvalid & wReady_q;
		arFire = s_axi_arvalid & arReady_q;
		if (bValid_q & s_axi_bready) begin
			bValid_d = 1'h0;
		end
		if (awFire) begin
			awHeld_d = 1'h1;
			awAddr_d = s_axi_awaddr;
		end
		if (wFire) begin
			wHeld_d = 1'h1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		// No software lock on G15-13: the boot-time input rule is on the driver
		if (awHeld_d & wHeld_d & ~bValid_d) begin
			unique case (awAddr_d)
				ADDR_G_CFG: gCfg_d = mergeBytes(gCfg_q, wData_d, wStrb_d);
				ADDR_G_DAT: gDat_d = G_PINS'(mergeBytes(BUS_W'(gDat_q), wData_d, wStrb_d));
				ADDR_G_UP: gUp_d = G_PINS'(mergeBytes(BUS_W'(gUp_q), wData_d, wStrb_d));
				ADDR_H_CFG: hCfg_d = H_CFG_W'(mergeBytes(BUS_W'(hCfg_q), wData_d, wStrb_d));
				ADDR_H_DAT: hDat_d = H_PINS'(mergeBytes(BUS_W'(hDat_q), wData_d, wStrb_d));
				ADDR_H_UP: hUp_d = H_PINS'(mergeBytes(BUS_W'(hUp_q), wData_d, wStrb_d));
				default: wrHit = 1'h0;
			endcase
			bResp_d = wrHit ? RESP_OKAY : RESP_SLVERR;
			bValid_d = 1'h1;
			awHeld_d = 1'h0;
			wHeld_d = 1'h0;
		end
		if (rValid_q & s_axi_rready) begin
			rValid_d = 1'h0;
		end
		if (arFire) begin
			rValid_d = 1'h1;
			rResp_d = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_G_CFG: rData_d = gCfg_q;
				ADDR_G_DAT: rData_d = BUS_W'(gLive);
				ADDR_G_UP: rData_d = BUS_W'(gUp_q);
				ADDR_H_CFG: rData_d = BUS_W'(hCfg_q);
				ADDR_H_DAT: rData_d = BUS_W'(hLive);
				ADDR_H_UP: rData_d = BUS_W'(hUp_q);
				default: begin
					rData_d = '0;
					rResp_d = RESP_SLVERR;
				end
			endcase
		end
		awReady_d = ~awHeld_d & ~bValid_d;
		wReady_d = ~wHeld_d & ~bValid_d;
		arReady_d = ~rValid_d;
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			{gCfg_q, gDat_q, gUp_q} <= {RST_G_CFG, RST_G_BITS, RST_G_BITS};
			{hCfg_q, hDat_q, hUp_q} <= {RST_H_CFG, RST_H_BITS, RST_H_BITS};
			{awHeld_q, awAddr_q, wHeld_q, wData_q, wStrb_q} <= '0;
			{bValid_q, rValid_q, rData_q} <= '0;
			{bResp_q, rResp_q} <= {RESP_OKAY, RESP_OKAY};
			// Readies start high so the first request is taken at once
			{awReady_q, wReady_q, arReady_q} <= '1;
		end else begin
			{gCfg_q, gDat_q, gUp_q, hCfg_q, hDat_q, hUp_q} <= {gCfg_d, gDat_d, gUp_d, hCfg_d, hDat_d, hUp_d};
			{awHeld_q, awAddr_q, wHeld_q, wData_q, wStrb_q} <= {awHeld_d, awAddr_d, wHeld_d, wData_d, wStrb_d};
			{bValid_q, bResp_q, rValid_q, rResp_q, rData_q} <= {bValid_d, bResp_d, rValid_d, rResp_d, rData_d};
			{awReady_q, wReady_q, arReady_q} <= {awReady_d, wReady_d, arReady_d};
		end
	end
	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rresp = rResp_q;
	assign s_axi_rdata = rData_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_g_output_mode: assert property ((gSel[0] == SEL_OUTPUT) |=> gPadOe[0] && gPadOut[0] == $past(gDat_q[0]))
		else $error("G0 output mode not driving data bit");
	chk_g_external_interrupt_line_route: assert property ((gSel[15] == SEL_ALT_A) |=> !gPadOe[15]
		&& externalInterruptLine[EXTERNAL_INTERRUPT_LINE_TOP] == $past(gPadIn[15]))
		else $error("G15 not routed to top interrupt line");
	chk_g_rts_alt: assert property ((gSel[PG_UART1_RTS] == SEL_ALT_B) |=> gPadOe[PG_UART1_RTS]
		&& gPadOut[PG_UART1_RTS] == $past(uart1RequestToSendN))
		else $error("G9 not driven by UART1 request-to-send");
	chk_g_data_read: assert property ((arFire && s_axi_araddr == ADDR_G_DAT && gSel[0] == SEL_INPUT)
		|=> s_axi_rvalid && s_axi_rdata[0] == $past(gPadIn[0]))
		else $error("G data read does not show pad level");
	chk_pullup_sense: assert property (##1 (gPullupEn[3] == !$past(gUp_q[3]) && hPullupEn[3] == !$past(hUp_q[3])))
		else $error("Pull-up enable does not follow disable bit");
	chk_h_output_mode: assert property ((hSel[10] == SEL_OUTPUT) |=> hPadOe[10] && hPadOut[10] == $past(hDat_q[10]))
		else $error("H10 output mode not driving data bit");
	chk_h_txd_alt: assert property ((hSel[PH_TXD0] == SEL_ALT_A) |=> hPadOe[PH_TXD0]
		&& hPadOut[PH_TXD0] == $past(uartTxd[0]))
		else $error("H2 not driven by UART0 transmit");
	chk_h_cts_alt: assert property ((hSel[PH_RXD2] == SEL_ALT_B && gSel[PG_UART1_CTS] != SEL_ALT_B)
		|=> !hPadOe[PH_RXD2] && uart1ClearToSendN == $past(hPadIn[PH_RXD2]))
		else $error("H7 not routed to UART1 clear-to-send");

	cov_write_done: cover property (bValid_q && bResp_q == RESP_OKAY && s_axi_bready);
	cov_read_done: cover property (rValid_q && rResp_q == RESP_OKAY && s_axi_rready);
	cov_bad_addr: cover property (bValid_q && bResp_q == RESP_SLVERR);
	cov_alt_spi: cover property (gSel[PG_SPI1_CLK] == SEL_ALT_B ##1 gPadOe[PG_SPI1_CLK]);

endmodule // dual_gpio_port_mux

// *** shared/gpio_mux_pkg.sv ***
package gpio_mux_pkg;

	// ==========================================
	// Port sizes
	localparam int G_PINS = 16;
	localparam int H_PINS = 11;
	localparam int G_CFG_W = 32;
	localparam int H_CFG_W = 22;
	localparam int SEL_W = 2;
	localparam int EXTERNAL_INTERRUPT_LINE_BASE = 8;
	localparam int EXTERNAL_INTERRUPT_LINE_TOP = 23;
	localparam int BUS_W = 32;
	localparam int STRB_W = 4;

	// ==========================================
	// Register byte addresses
	localparam logic [31:0] ADDR_G_CFG = 32'h5600_0060;
	localparam logic [31:0] ADDR_G_DAT = 32'h5600_0064;
	localparam logic [31:0] ADDR_G_UP = 32'h5600_0068;
	localparam logic [31:0] ADDR_H_CFG = 32'h5600_0070;
	localparam logic [31:0] ADDR_H_DAT = 32'h5600_0074;
	localparam logic [31:0] ADDR_H_UP = 32'h5600_0078;

	// ==========================================
	// Reset values (all pins input, pull-ups on)
	localparam logic [G_CFG_W-1:0] RST_G_CFG = 32'h0000_0000;
	localparam logic [H_CFG_W-1:0] RST_H_CFG = 22'h00_0000;
	localparam logic [G_PINS-1:0] RST_G_BITS = 16'h0000;
	localparam logic [H_PINS-1:0] RST_H_BITS = 11'h000;

	// ==========================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// Pin selector codes
	typedef enum logic [1:0] {
		SEL_INPUT = 2'h0,
		SEL_OUTPUT = 2'h1,
		SEL_ALT_A = 2'h2,
		SEL_ALT_B = 2'h3
	} pin_sel_t;

	// ==========================================
	// Alternate pin positions, port G
	localparam int PG_TIMER_CLK = 11;
	localparam int PG_UART1_CTS = 10;
	localparam int PG_UART1_RTS = 9;
	localparam int PG_SPI1_CLK = 7;
	localparam int PG_SPI1_MOSI = 6;
	localparam int PG_SPI1_MISO = 5;
	localparam int PG_LCD_PD = 4;
	localparam int PG_SPI1_SEL = 3;
	localparam int PG_SPI0_SEL = 2;

	// ==========================================
	// Alternate pin positions, port H
	localparam int PH_CLOCK_OUTPUT_ONE = 10;
	localparam int PH_CLOCK_OUTPUT_ZERO = 9;
	localparam int PH_UART_CLK = 8;
	localparam int PH_RXD2 = 7;
	localparam int PH_TXD2 = 6;
	localparam int PH_RXD1 = 5;
	localparam int PH_TXD1 = 4;
	localparam int PH_RXD0 = 3;
	localparam int PH_TXD0 = 2;
	localparam int PH_UART0_RTS = 1;
	localparam int PH_UART0_CTS = 0;

	// ==========================================
	// Serial peripheral pin bundle
	typedef struct packed {
		logic clock;
		logic masterOut;
		logic masterIn;
		logic selectN;
	} spi_pins_t;

endpackage

// *** verilog/gpio_pin_cell.sv ***
`timescale 1ns/10ps
module gpio_pin_cell (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Pin settings
	input wire gpio_mux_pkg::pin_sel_t sel,
	input wire logic dataBit,
	input wire logic pullupDisable,
	// Alternate function drive
	input wire logic altAOut,
	input wire logic altAOe,
	input wire logic altBOut,
	input wire logic altBOe,
	// Pad side
	output logic padOut,
	output logic padOe,
	output logic pullupEn
);
	import gpio_mux_pkg::*;

	logic padOut_d, padOe_d, pullupEn_d;

	// ==========================================
	// Pad drive
	always_comb begin
		padOut_d = 1'h0;
		padOe_d = 1'h0;
		unique case (sel)
			SEL_INPUT: padOe_d = 1'h0;
			SEL_OUTPUT: begin
				padOe_d = 1'h1;
				padOut_d = dataBit;
			end
			SEL_ALT_A: begin
				padOe_d = altAOe;
				padOut_d = altAOut;
			end
			SEL_ALT_B: begin
				padOe_d = altBOe;
				padOut_d = altBOut;
			end
		endcase
		// Active low sense: a set bit turns the pull-up off
		pullupEn_d = ~pullupDisable;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			padOut <= 1'h0;
			padOe <= 1'h0;
			pullupEn <= 1'h1;
		end else begin
			padOut <= padOut_d;
			padOe <= padOe_d;
			pullupEn <= pullupEn_d;
		end
	end

endmodule // gpio_pin_cell

// *** verif/pad_partner.sv ***
`timescale 1ns/10ps
// ==========================================
// Board side of one pad group
module pad_partner #(parameter int W = 16) (
	// Clock
	input wire logic core_clk,
	// Device pad drive
	input wire logic [W-1:0] padOut,
	input wire logic [W-1:0] padOe,
	input wire logic [W-1:0] pullupEn,
	// Board drive
	input wire logic [W-1:0] extVal,
	input wire logic [W-1:0] extEn,
	// Resolved pad level
	output logic [W-1:0] padIn
);
	logic [W-1:0] last_q = '0;
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (padOe[i]) padIn[i] = padOut[i];
			else if (extEn[i]) padIn[i] = extVal[i];
			else if (pullupEn[i]) padIn[i] = 1'b1;
			// Floating pad toggles so a stale level never reads back
			else padIn[i] = ~last_q[i];
		end
	end
	always_ff @(posedge core_clk) last_q <= padIn;
endmodule // pad_partner

// *** verif/tb_dual_gpio_port_mux.sv ***
`timescale 1ns/10ps
module tb_dual_gpio_port_mux;
	import gpio_mux_pkg::*;
	// ==========================================
	// Signals
	localparam logic [31:0] ADDRS [7] = '{ADDR_G_CFG, ADDR_G_DAT, ADDR_G_UP, ADDR_H_CFG, ADDR_H_DAT, ADDR_H_UP,
		32'h5600_006C};
	localparam logic [31:0] MASK [7] = '{32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h003F_FFFF, 32'h0000_07FF,
		32'h0000_07FF, 32'h0};
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] gPadIn, gPadOut, gPadOe, gPullupEn, gExt = '0;
	logic [10:0] hPadIn, hPadOut, hPadOe, hPullupEn, hExt = '0;
	logic [23:8] externalInterruptLine;
	logic timerClockInOne, uart1ClearToSendN, serialPeriph0SelectNIn, uartExternalClock, uart0ClearToSendN;
	logic uart1RequestToSendN = 1, serialPeriph0SelectNOut = 1, serialPeriph0SelectNOe = 0, displayPowerDown = 0;
	logic clockOutputOne = 0, clockOutputZero = 0, uart0RequestToSendN = 1;
	logic [2:0] uartTxd = '0, uartRxd;
	spi_pins_t spi1DriveOut = '0, spi1DriveOe = '0, spi1PadIn;
	int failCount = 0, checkCount = 0, cycles = 0;
	logic [31:0] mdl [6];
	logic [15:0] e, f, eo, eu, lv;
	// ==========================================
	// Instances
	dual_gpio_port_mux dut (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gPadIn,
		.gPadOut, .gPadOe, .gPullupEn, .hPadIn, .hPadOut, .hPadOe, .hPullupEn, .externalInterruptLine,
		.timerClockInOne, .uart1ClearToSendN, .uart1RequestToSendN, .spi1DriveOut, .spi1DriveOe, .spi1PadIn,
		.serialPeriph0SelectNOut, .serialPeriph0SelectNOe, .serialPeriph0SelectNIn, .displayPowerDown,
		.clockOutputOne, .clockOutputZero, .uartExternalClock, .uartTxd, .uartRxd, .uart0RequestToSendN,
		.uart0ClearToSendN);
	pad_partner #(.W(16)) gSide (.core_clk, .padOut(gPadOut), .padOe(gPadOe), .pullupEn(gPullupEn),
		.extVal(gExt), .extEn(16'hFFFF), .padIn(gPadIn));
	pad_partner #(.W(11)) hSide (.core_clk, .padOut(hPadOut), .padOe(hPadOe), .pullupEn(hPullupEn),
		.extVal(hExt), .extEn(11'h7FF), .padIn(hPadIn));
	// ==========================================
	// Clock and watchdog
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 8000) begin
			failCount++;
			closeOut();
		end
	end
	// ==========================================
	// Tasks
	task automatic closeOut();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			failCount++;
		end
	endtask
	task automatic axw(input int i, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= ADDRS[i];
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, (i == 6) ? RESP_SLVERR : RESP_OKAY);
		if (i < 6) mdl[i] = d & MASK[i];
	endtask
	task automatic axr(input int i, input logic [31:0] exp);
		@(posedge core_clk);
		s_axi_araddr <= ADDRS[i];
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, (i == 6) ? 32'h0 : exp);
		chk(s_axi_rresp, (i == 6) ? RESP_SLVERR : RESP_OKAY);
	endtask
	task automatic shuffle();
		gExt <= 16'($urandom);
		hExt <= 11'($urandom);
		uart1RequestToSendN <= 1'($urandom);
		spi1DriveOut <= 4'($urandom);
		spi1DriveOe <= 4'($urandom);
		serialPeriph0SelectNOut <= 1'($urandom);
		serialPeriph0SelectNOe <= 1'($urandom);
		displayPowerDown <= 1'($urandom);
		clockOutputOne <= 1'($urandom);
		clockOutputZero <= 1'($urandom);
		uartTxd <= 3'($urandom);
		uart0RequestToSendN <= 1'($urandom);
	endtask
	// Settings reach the pads two edges late, pad levels one more
	task automatic settle();
		repeat (4) @(posedge core_clk);
	endtask
	function automatic logic [15:0] oeOf(input logic [31:0] c);
		logic [15:0] r;
		for (int n = 0; n < 16; n++) r[n] = (c[2*n+:2] == 2'h1);
		return r;
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h48B6));
		for (int i = 0; i < 6; i++) mdl[i] = '0;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		shuffle();
		settle();
		chk(gPadOe, 16'h0);
		chk(hPadOe, 11'h0);
		chk(gPullupEn, 16'hFFFF);
		chk(hPullupEn, 11'h7FF);
		chk(externalInterruptLine, 16'h0);
		chk(timerClockInOne, 1'b0);
		chk(spi1PadIn, 4'h1);
		chk(serialPeriph0SelectNIn, 1'b1);
		chk(uartRxd, 3'h7);
		chk(uart0ClearToSendN, 1'b1);
		chk(uartExternalClock, 1'b0);
		chk(uart1ClearToSendN, 1'b1);
		for (int i = 0; i < 7; i++) axr(i, (i == 1) ? gExt : (i == 4) ? hExt : 32'h0);
		axw(6, $urandom);
		axw(2, $urandom);
		axw(5, $urandom);
		settle();
		chk(gPullupEn, 16'(~mdl[2][15:0]));
		chk(hPullupEn, 11'(~mdl[5][10:0]));
		axr(2, mdl[2]);
		axr(5, mdl[5]);
		for (int k = 0; k < 4; k++) begin
			shuffle();
			axw(0, $urandom & 32'h5555_5555);
			axw(1, $urandom);
			axw(3, $urandom & 32'h0015_5555);
			axw(4, $urandom);
			settle();
			e = oeOf(mdl[0]);
			f = oeOf(mdl[3]);
			chk(gPadOe, e);
			chk(gPadOut & e, mdl[1][15:0] & e);
			axr(1, (mdl[1] & e) | (gExt & ~e));
			chk(hPadOe, f[10:0]);
			chk(hPadOut & f[10:0], mdl[4][10:0] & f[10:0]);
			axr(4, (mdl[4] & f) | (hExt & ~f[10:0]));
			axr(0, mdl[0]);
			axr(3, mdl[3]);
		end
		shuffle();
		// All sixteen G pins double as wake sources in interrupt mode
		axw(0, 32'hAAAA_AAAA);
		settle();
		chk(externalInterruptLine, gExt);
		chk(gPadOe, 16'h0);
		shuffle();
		// Top three pins stay inputs, as a flash boot needs
		axw(0, 32'h03FF_FFFF);
		settle();
		eo = {6'h0, 1'b1, 1'b0, spi1DriveOe.clock, spi1DriveOe.masterOut, spi1DriveOe.masterIn, 1'b1,
			spi1DriveOe.selectN, serialPeriph0SelectNOe, 2'h0};
		eu = {6'h0, uart1RequestToSendN, 1'b0, spi1DriveOut.clock, spi1DriveOut.masterOut, spi1DriveOut.masterIn,
			displayPowerDown, spi1DriveOut.selectN, serialPeriph0SelectNOut, 2'h0};
		lv = (eu & eo) | (gExt & ~eo);
		chk(gPadOe, eo);
		chk(gPadOut & eo, eu & eo);
		chk(timerClockInOne, gExt[11]);
		chk(uart1ClearToSendN, gExt[10]);
		chk(spi1PadIn, {lv[7], lv[6], lv[5], lv[3]});
		chk(serialPeriph0SelectNIn, lv[2]);
		axr(1, lv);
		shuffle();
		axw(3, 32'h002A_AAAA);
		settle();
		eu = {5'h0, clockOutputOne, clockOutputZero, 2'h0, uartTxd[2], 1'b0, uartTxd[1], 1'b0, uartTxd[0],
			uart0RequestToSendN, 1'b0};
		chk(hPadOe, 11'h656);
		chk(hPadOut & 11'h656, eu[10:0] & 11'h656);
		chk(uartExternalClock, hExt[8]);
		chk(uartRxd, {hExt[7], hExt[5], hExt[3]});
		chk(uart0ClearToSendN, hExt[0]);
		chk(uart1ClearToSendN, gExt[10]);
		shuffle();
		axw(3, 32'h003F_FFFF);
		settle();
		chk(hPadOe, 11'h040);
		chk(hPadOut[6], uart1RequestToSendN);
		chk(gPadOut[9], uart1RequestToSendN);
		chk(uart1ClearToSendN, gExt[10] & hExt[7]);
		chk(uartRxd, 3'h7);
		// Handshake from H7 alone once G10 is back to input
		axw(0, 32'h0);
		settle();
		chk(uart1ClearToSendN, hExt[7]);
		chk(gPadOe, 16'h0);
		closeOut();
	end
endmodule // tb_dual_gpio_port_mux
